// ### src/sei_dev.sv
// What this block does
// R1 - Master starts transfers and makes the clock
// R2 - Start: data falls while clock high
// R3 - Start precedes commands; silent until one seen
// R4 - Stop: data rises while clock high
// R5 - Stop ends read only after master not-ack
// R6 - Stop after write launches programming cycle
// R7 - Transmitter releases; receiver acks ninth pulse
// R8 - Sample data on rising serial clock
// R9 - Master changes data only while clock low
// R10 - Select byte: seven bits, direction, MSB first
// R11 - Compare select bits 6..4 with chip selects
// R12 - Direction bit one reads, zero writes
// R13 - Matching select is acked in ninth slot
// R14 - Mismatch: release bus, standby until start
// R15 - Write: ack select, ack address, take data
// R16 - Protect high anywhere: refuse data, no write
// R17 - Single write: one data byte, then stop
// R18 - Unconnected protect input reads as low
// R19 - Protected: select and address still acked
// R20 - Location is upper bits then byte address
// R21 - Programming: ignore bus; length is parameter
`timescale 1ns/1ps
module sei_dev #(
  parameter int WRITE_CYC = sei_pkg::WRITE_CYC
) (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        SYS_RST,
  // Two-wire link
  sei_if.dev                               LINK,
  // Straps
  input  wire logic                        CHIP_SELECT_IN_2,
  input  wire logic                        CHIP_SELECT_IN_1,
  input  wire logic                        CHIP_SELECT_IN_0,
  input  wire logic                        WRITE_PROTECT_INPUT,
  // Programming requests
  output logic                             WR_VALID,
  input  wire logic                        WR_READY,
  output logic [sei_pkg::ADDR_W-1:0]       WR_ADDR,
  output logic [sei_pkg::DATA_W-1:0]       WR_DATA,
  output logic                             PROG_BUSY
);

  localparam int PW = $clog2(WRITE_CYC + 1);

  typedef enum logic [8:0] {
    S_STBY     = 9'h001,
    S_SEL      = 9'h002,
    S_SEL_ACK  = 9'h004,
    S_ADDR     = 9'h008,
    S_ADDR_ACK = 9'h010,
    S_DATA     = 9'h020,
    S_DATA_ACK = 9'h040,
    S_READ     = 9'h080,
    S_PROG     = 9'h100
  } seidev_state_t;

  typedef struct packed {
    seidev_state_t                st;
    logic                         scl_s1;
    logic                         scl_s2;
    logic                         scl_d;
    logic                         sda_s1;
    logic                         sda_s2;
    logic                         sda_d;
    logic                         wp_s1;
    logic                         wp_s2;
    logic [2:0]                   cs_s1;
    logic [2:0]                   cs_s2;
    logic [3:0]                   cnt;
    logic [7:0]                   sh;
    logic                         sda_oe_n;
    logic                         wp_seen;
    logic                         rw;
    logic                         nack;
    logic                         have;
    logic [2:0]                   ahi;
    logic [7:0]                   addr;
    logic [7:0]                   data;
    logic [PW-1:0]                pcnt;
    logic                         busy;
    logic                         o_v;
    logic [sei_pkg::WORD_W-1:0]   o_w;
    logic                         s_v;
    logic [sei_pkg::WORD_W-1:0]   s_w;
  } seidev_reg_t;

  seidev_reg_t r_r;
  seidev_reg_t r_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic wp_now;
  logic buf_rdy;
  logic sel_match;

  // Edge and condition detection compares second-stage samples with their one-cycle-delayed copies
  assign scl_rise  = r_r.scl_s2 & ~r_r.scl_d;
  assign scl_fall  = ~r_r.scl_s2 & r_r.scl_d;
  assign start_det = r_r.scl_s2 & r_r.scl_d & r_r.sda_d & ~r_r.sda_s2; // R2
  assign stop_det  = r_r.scl_s2 & r_r.scl_d & ~r_r.sda_d & r_r.sda_s2; // R4
  // A floating pin is pulled low at the pad, so only a clear high protects
  assign wp_now    = r_r.wp_s2; // R18
  assign buf_rdy   = ~r_r.s_v;
  assign sel_match = (r_r.sh[sei_pkg::SEL_FIX_BIT] == sei_pkg::SEL_FIX_VAL) &&
                     (r_r.sh[sei_pkg::SEL_CS_HI:sei_pkg::SEL_CS_LO] == r_r.cs_s2); // R11

  always_comb begin
    r_nxt = r_r;
    r_nxt.scl_s1 = LINK.scl;
    r_nxt.scl_s2 = r_r.scl_s1;
    r_nxt.scl_d  = r_r.scl_s2;
    r_nxt.sda_s1 = LINK.sda_line;
    r_nxt.sda_s2 = r_r.sda_s1;
    r_nxt.sda_d  = r_r.sda_s2;
    r_nxt.wp_s1  = WRITE_PROTECT_INPUT;
    r_nxt.wp_s2  = r_r.wp_s1;
    r_nxt.cs_s1  = {CHIP_SELECT_IN_2, CHIP_SELECT_IN_1, CHIP_SELECT_IN_0};
    r_nxt.cs_s2  = r_r.cs_s1;
    if (wp_now) begin
      r_nxt.wp_seen = 1'b1; // R16
    end

    // Two-entry output buffer: pop first, so a push sees the freed slot
    if (r_r.o_v && WR_READY) begin
      r_nxt.o_v = r_r.s_v;
      r_nxt.o_w = r_r.s_w;
      r_nxt.s_v = 1'b0;
    end

    if (r_r.st == S_PROG) begin
      // Bus is not watched at all while the array is being written
      if (r_r.pcnt == '0) begin // R21
        r_nxt.st = S_STBY;
      end else begin
        r_nxt.pcnt = r_r.pcnt - PW'(1);
      end
    end else if (start_det) begin // R3
      r_nxt.st       = S_SEL;
      r_nxt.cnt      = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
      r_nxt.wp_seen  = wp_now; // R16
      r_nxt.have     = 1'b0;
      r_nxt.nack     = 1'b0;
    end else if (stop_det) begin
      r_nxt.sda_oe_n = 1'b1;
      r_nxt.cnt      = 4'h0;
      if (r_r.st == S_DATA && r_r.have && !r_r.wp_seen && !wp_now) begin // R6
        if (!r_nxt.o_v) begin
          r_nxt.o_v = 1'b1;
          r_nxt.o_w = {r_r.ahi, r_r.addr, r_r.data}; // R20
        end else begin
          r_nxt.s_v = 1'b1;
          r_nxt.s_w = {r_r.ahi, r_r.addr, r_r.data}; // R20
        end
        r_nxt.st   = S_PROG;
        r_nxt.pcnt = PW'(WRITE_CYC - 1);
      end else if (r_r.st == S_READ && !r_r.nack) begin // R5
        r_nxt.st = S_READ;
      end else begin
        r_nxt.st = S_STBY; // R4
      end
    end else begin
      unique case (r_r.st)
        S_STBY: begin
          r_nxt.sda_oe_n = 1'b1; // R3
        end
        S_SEL, S_ADDR, S_DATA: begin
          if (scl_rise) begin
            r_nxt.sh  = {r_r.sh[6:0], r_r.sda_s2}; // R8
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (scl_fall && r_r.cnt == sei_pkg::BYTE_BITS) begin
            r_nxt.cnt = 4'h0;
            if (r_r.st == S_SEL) begin
              if (sel_match) begin
                r_nxt.sda_oe_n = 1'b0; // R13
                r_nxt.rw       = r_r.sh[sei_pkg::SEL_RW_BIT]; // R12
                r_nxt.ahi      = r_r.sh[sei_pkg::SEL_AHI_HI:sei_pkg::SEL_AHI_LO];
                r_nxt.st       = S_SEL_ACK;
              end else begin
                r_nxt.st = S_STBY; // R14
              end
            end else if (r_r.st == S_ADDR) begin
              r_nxt.addr     = r_r.sh;
              r_nxt.sda_oe_n = 1'b0; // R19
              r_nxt.st       = S_ADDR_ACK;
            end else begin
              // A full buffer is refused like protection, so no word is lost
              if (!(r_r.wp_seen || wp_now) && buf_rdy) begin // R16
                r_nxt.data     = r_r.sh;
                r_nxt.have     = 1'b1;
                r_nxt.sda_oe_n = 1'b0; // R17
              end else begin
                r_nxt.have = 1'b0;
              end
              r_nxt.st = S_DATA_ACK;
            end
          end
        end
        S_SEL_ACK, S_ADDR_ACK, S_DATA_ACK: begin
          if (scl_rise) begin
            r_nxt.cnt = 4'h1;
          end
          if (scl_fall && r_r.cnt == 4'h1) begin // R7
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.cnt      = 4'h0;
            if (r_r.st == S_SEL_ACK) begin
              r_nxt.st = (r_r.rw == sei_pkg::RW_READ) ? S_READ : S_ADDR; // R15
            end else begin
              r_nxt.st = S_DATA; // R15
            end
          end
        end
        S_READ: begin
          // No array path here: data bits are sent as released (all ones)
          r_nxt.sda_oe_n = 1'b1; // R7
          if (scl_rise) begin
            if (r_r.cnt == sei_pkg::ACK_BIT) begin
              r_nxt.nack = r_r.sda_s2; // R5
            end
            r_nxt.cnt = r_r.cnt + 4'h1;
          end
          if (scl_fall && r_r.cnt == sei_pkg::ACK_DONE) begin
            r_nxt.cnt = 4'h0;
          end
        end
        S_PROG: begin
          r_nxt.sda_oe_n = 1'b1; // R21
        end
      endcase
    end
    r_nxt.busy = (r_nxt.st == S_PROG);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_r          <= '0;
      r_r.st       <= S_STBY;
      r_r.sda_oe_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign LINK.dev_sda_oe_n = r_r.sda_oe_n;
  assign WR_VALID          = r_r.o_v;
  assign WR_ADDR           = r_r.o_w[sei_pkg::WORD_W-1:sei_pkg::DATA_W];
  assign WR_DATA           = r_r.o_w[sei_pkg::DATA_W-1:0];
  assign PROG_BUSY         = r_r.busy;

endmodule : sei_dev

// ### common/sei_pkg.sv
package sei_pkg;

  // System clock
  localparam int CLK_MHZ        = 125;

  // Serial clock made by the master end
  localparam int SCL_PERIOD_NS  = 2500;
  localparam int SCL_QTR_CYC    = (SCL_PERIOD_NS * CLK_MHZ) / 4000;

  // Self-timed programming cycle
  localparam int WRITE_TIME_MS  = 5;
  localparam int WRITE_CYC      = WRITE_TIME_MS * CLK_MHZ * 1000;

  // Select byte layout
  localparam int SEL_FIX_BIT    = 7;
  localparam int SEL_CS_HI      = 6;
  localparam int SEL_CS_LO      = 4;
  localparam int SEL_AHI_HI     = 3;
  localparam int SEL_AHI_LO     = 1;
  localparam int SEL_RW_BIT     = 0;
  localparam logic SEL_FIX_VAL  = 1'b1;
  localparam logic RW_READ      = 1'b1;

  // Widths and counts
  localparam int ADDR_W         = 11;
  localparam int DATA_W         = 8;
  localparam int WORD_W         = ADDR_W + DATA_W;
  localparam int CMD_W          = 1 + 3 + ADDR_W + DATA_W;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [3:0] ACK_DONE  = 4'h9;
  localparam logic [1:0] WR_BYTES  = 2'h3;
  localparam logic [1:0] RD_BYTES  = 2'h2;

endpackage : sei_pkg

// ### common/sei_if.sv
`timescale 1ns/1ps
interface sei_if;
  logic scl;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic sda_line;

  // Open-drain data line with pull-up: low while either end enables its driver
  assign sda_line = host_sda_oe_n & dev_sda_oe_n;

  modport host (output scl, output host_sda_oe_n, input sda_line);
  modport dev  (input scl, input sda_line, output dev_sda_oe_n);
endinterface : sei_if

// ### src/sei_host.sv
`timescale 1ns/1ps
module sei_host (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        SYS_RST,
  // Two-wire link
  sei_if.host                              LINK,
  // Commands
  input  wire logic                        CMD_VALID,
  output logic                             CMD_READY,
  input  wire logic                        CMD_RD,
  input  wire logic [2:0]                  CMD_CS,
  input  wire logic [sei_pkg::ADDR_W-1:0]  CMD_ADDR,
  input  wire logic [sei_pkg::DATA_W-1:0]  CMD_DATA,
  // Responses
  output logic                             RSP_VALID,
  output logic                             RSP_NACK,
  output logic [sei_pkg::DATA_W-1:0]       RSP_DATA,
  output logic                             BUSY
);

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } seihst_state_t;

  typedef struct packed {
    seihst_state_t               st;
    logic [1:0]                  ph;
    logic [7:0]                  qcnt;
    logic [3:0]                  bit_i;
    logic [1:0]                  byte_i;
    logic                        scl;
    logic                        sda_oe_n;
    logic                        sda_s1;
    logic                        sda_s2;
    logic                        nack;
    logic [7:0]                  rx;
    logic [sei_pkg::CMD_W-1:0]   cur;
    logic                        o_v;
    logic [sei_pkg::CMD_W-1:0]   o_w;
    logic                        s_v;
    logic [sei_pkg::CMD_W-1:0]   s_w;
    logic                        cmd_rdy;
    logic                        rsp_v;
    logic                        rsp_nack;
    logic [7:0]                  rsp_data;
    logic                        busy;
  } seihst_reg_t;

  seihst_reg_t r_r;
  seihst_reg_t r_nxt;

  logic                      tick;
  logic                      cur_rd;
  logic                      rx_byte;
  logic                      last_byte;
  logic [7:0]                tx_byte;

  assign tick      = (r_r.qcnt == 8'(sei_pkg::SCL_QTR_CYC - 1));
  assign cur_rd    = r_r.cur[sei_pkg::CMD_W-1];
  assign rx_byte   = cur_rd && (r_r.byte_i == 2'h1);
  assign last_byte = (r_r.byte_i == ((cur_rd ? sei_pkg::RD_BYTES : sei_pkg::WR_BYTES) - 2'h1));

  always_comb begin
    unique case (r_r.byte_i)
      2'h0:    tx_byte = {sei_pkg::SEL_FIX_VAL, r_r.cur[sei_pkg::CMD_W-2 -: 3],
                          r_r.cur[sei_pkg::WORD_W-1 -: 3], cur_rd}; // R10 R12
      2'h1:    tx_byte = r_r.cur[sei_pkg::DATA_W +: 8];
      default: tx_byte = r_r.cur[7:0];
    endcase
  end

  always_comb begin
    r_nxt          = r_r;
    r_nxt.sda_s1   = LINK.sda_line;
    r_nxt.sda_s2   = r_r.sda_s1;
    r_nxt.rsp_v    = 1'b0;
    r_nxt.qcnt     = (r_r.st == H_IDLE || tick) ? 8'h00 : r_r.qcnt + 8'h01;

    // Command buffer: two entries, so two commands wait while one runs
    if (CMD_VALID && !r_r.s_v) begin
      if (!r_r.o_v) begin
        r_nxt.o_v = 1'b1;
        r_nxt.o_w = {CMD_RD, CMD_CS, CMD_ADDR, CMD_DATA};
      end else begin
        r_nxt.s_v = 1'b1;
        r_nxt.s_w = {CMD_RD, CMD_CS, CMD_ADDR, CMD_DATA};
      end
    end

    unique case (r_r.st)
      H_IDLE: begin
        r_nxt.scl      = 1'b1;
        r_nxt.sda_oe_n = 1'b1;
        if (r_r.o_v) begin
          r_nxt.cur    = r_r.o_w;
          r_nxt.o_v    = r_nxt.s_v;
          r_nxt.o_w    = r_nxt.s_w;
          r_nxt.s_v    = 1'b0;
          r_nxt.st     = H_START;
          r_nxt.ph     = 2'h0;
          r_nxt.bit_i  = 4'h0;
          r_nxt.byte_i = 2'h0;
          r_nxt.nack   = 1'b0;
        end
      end
      H_START: begin
        if (tick) begin
          r_nxt.ph = r_r.ph + 2'h1;
          if (r_r.ph == 2'h2) begin
            r_nxt.sda_oe_n = 1'b0; // R1
          end
          if (r_r.ph == 2'h3) begin
            r_nxt.scl = 1'b0;
            r_nxt.st  = H_BIT;
          end
        end
      end
      H_BIT: begin
        if (tick) begin
          r_nxt.ph = r_r.ph + 2'h1;
          unique case (r_r.ph)
            2'h0: begin
              // Data moves only in the low phase of the clock
              if (r_r.bit_i < sei_pkg::BYTE_BITS && !rx_byte) begin // R9
                r_nxt.sda_oe_n = tx_byte[3'(7 - r_r.bit_i)]; // R10
              end else begin
                r_nxt.sda_oe_n = 1'b1; // R7
              end
            end
            2'h1: r_nxt.scl = 1'b1;
            2'h2: begin
              if (r_r.bit_i < sei_pkg::BYTE_BITS && rx_byte) begin
                r_nxt.rx = {r_r.rx[6:0], r_r.sda_s2};
              end
              if (r_r.bit_i == sei_pkg::ACK_BIT && !rx_byte && r_r.sda_s2) begin
                r_nxt.nack = 1'b1;
              end
            end
            2'h3: begin
              r_nxt.scl = 1'b0;
              if (r_r.bit_i == sei_pkg::ACK_BIT) begin
                r_nxt.bit_i = 4'h0;
                if (last_byte || r_nxt.nack) begin
                  r_nxt.st = H_STOP; // R17
                end else begin
                  r_nxt.byte_i = r_r.byte_i + 2'h1;
                end
              end else begin
                r_nxt.bit_i = r_r.bit_i + 4'h1;
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          r_nxt.ph = r_r.ph + 2'h1;
          unique case (r_r.ph)
            2'h0: r_nxt.sda_oe_n = 1'b0;
            2'h1: r_nxt.scl = 1'b1;
            2'h2: r_nxt.sda_oe_n = 1'b1;
            2'h3: begin
              r_nxt.st       = H_IDLE;
              r_nxt.rsp_v    = 1'b1;
              r_nxt.rsp_nack = r_r.nack;
              r_nxt.rsp_data = r_r.rx;
            end
          endcase
        end
      end
    endcase
    r_nxt.cmd_rdy = ~r_nxt.s_v;
    r_nxt.busy    = (r_nxt.st != H_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_r          <= '0;
      r_r.st       <= H_IDLE;
      r_r.scl      <= 1'b1;
      r_r.sda_oe_n <= 1'b1;
      r_r.cmd_rdy  <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign LINK.scl           = r_r.scl;
  assign LINK.host_sda_oe_n = r_r.sda_oe_n;
  assign CMD_READY          = r_r.cmd_rdy;
  assign RSP_VALID          = r_r.rsp_v;
  assign RSP_NACK           = r_r.rsp_nack;
  assign RSP_DATA           = r_r.rsp_data;
  assign BUSY               = r_r.busy;

endmodule : sei_host

// ### bench/sei_link_sva.sv
`timescale 1ns/1ps
module sei_link_sva #(
  parameter int WRITE_CYC = 200
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Link
  input wire logic scl,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic sda_line
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frame_r;
  logic [5:0] rise_cnt_r;
  logic [1:0] ack_cnt_r;
  int         quiet_r;
  wire        start = scl && scl_q && sda_q && !sda_line;
  wire        stop  = scl && scl_q && !sda_q && sda_line;

  // Margin of a few cycles covers the device's line synchronisers
  always_ff @(posedge CLK) begin
    scl_q <= scl;
    sda_q <= sda_line;
    if (SYS_RST) begin
      in_frame_r <= 1'b0;
      rise_cnt_r <= 6'h00;
      ack_cnt_r  <= 2'h0;
      quiet_r    <= 0;
    end else begin
      if (start) begin
        in_frame_r <= 1'b1;
        rise_cnt_r <= 6'h00;
        ack_cnt_r  <= 2'h0;
      end else begin
        if (stop)
          in_frame_r <= 1'b0;
        if (scl && !scl_q && rise_cnt_r != 6'h3F)
          rise_cnt_r <= rise_cnt_r + 6'h01;
      end
      if (in_frame_r && !dev_sda_oe_n && $past(dev_sda_oe_n))
        ack_cnt_r <= ack_cnt_r + 2'h1;
      if (stop && ack_cnt_r == 2'h3)
        quiet_r <= WRITE_CYC - 8;
      else if (quiet_r != 0)
        quiet_r <= quiet_r - 1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_scl_fell_4ago;
    $past(scl, 4) && !$past(scl, 3);
  endsequence

  sequence s_ack_low_8;
    (!dev_sda_oe_n)[*8];
  endsequence

  a_dev_steady_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device data changed while clock high");
  a_ack_bit_slot: assert property ($fell(dev_sda_oe_n) |-> in_frame_r && rise_cnt_r == 8 + 9 * ack_cnt_r)
    else $error("device drive outside an acknowledge slot");
  a_ack_release_slot: assert property ($rose(dev_sda_oe_n) |-> !scl && rise_cnt_r == 9 * ack_cnt_r)
    else $error("device release not after ninth clock");
  a_ack_drive_delay: assert property ($fell(dev_sda_oe_n) |-> s_scl_fell_4ago)
    else $error("acknowledge drive not four cycles after clock fall");
  a_ack_release_delay: assert property ($rose(dev_sda_oe_n) |-> s_scl_fell_4ago)
    else $error("release not four cycles after clock fall");
  a_ack_holds_high: assert property ($rose(scl) && !dev_sda_oe_n |=> s_ack_low_8)
    else $error("acknowledge dropped during clock high");
  a_prog_quiet: assert property (quiet_r != 0 |-> dev_sda_oe_n)
    else $error("device drove line while programming");
  a_idle_silent: assert property (!in_frame_r |-> dev_sda_oe_n)
    else $error("device drove line outside a frame");
  // With clock high the host may only open a frame or close it after an acknowledge
  a_host_data_low: assert property (scl && $past(scl) && $changed(host_sda_oe_n) |->
    ($fell(host_sda_oe_n) && !in_frame_r) || ($rose(host_sda_oe_n) && in_frame_r && rise_cnt_r % 9 == 1))
    else $error("host data changed while clock high");
endmodule : sei_link_sva

// ### bench/serial_eeprom_i2c_slave_front_end_test.sv
`timescale 1ns/1ps
module serial_eeprom_i2c_slave_front_end_test;
  // Programming must outlast the select byte of the next frame
  localparam int WCYC  = 4000;
  localparam int LIMIT = 95000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_rd = 1'b0;
  logic [2:0]  cmd_cs = 3'h0;
  logic [10:0] cmd_addr = 11'h000;
  logic [7:0]  cmd_data = 8'h00;
  logic [2:0]  strap = 3'h5;
  logic        protect = 1'b0;
  logic        wr_ready = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_nack, busy, wr_valid, prog_busy;
  logic [7:0]  rsp_data, wr_data;
  logic [10:0] wr_addr;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          acks = 0;
  int          acks_at = 0;

  sei_if u_sei_if ();
  sei_host u_sei_host (.CLK(clk), .SYS_RST(rst), .LINK(u_sei_if.host), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_RD(cmd_rd), .CMD_CS(cmd_cs), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
    .RSP_VALID(rsp_valid), .RSP_NACK(rsp_nack), .RSP_DATA(rsp_data), .BUSY(busy));
  sei_dev #(.WRITE_CYC(WCYC)) u_sei_dev (.CLK(clk), .SYS_RST(rst), .LINK(u_sei_if.dev),
    .CHIP_SELECT_IN_2(strap[2]), .CHIP_SELECT_IN_1(strap[1]), .CHIP_SELECT_IN_0(strap[0]),
    .WRITE_PROTECT_INPUT(protect), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .PROG_BUSY(prog_busy));
  sei_link_sva #(.WRITE_CYC(WCYC)) u_sei_link_sva (.CLK(clk), .SYS_RST(rst), .scl(u_sei_if.scl),
    .host_sda_oe_n(u_sei_if.host_sda_oe_n), .dev_sda_oe_n(u_sei_if.dev_sda_oe_n),
    .sda_line(u_sei_if.sda_line));

  always #4 clk = ~clk;

  // Every acknowledge the device drives, so refused bytes can be told apart
  always @(negedge u_sei_if.dev_sda_oe_n) acks++;

  task automatic complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic send(input logic rd, input logic [2:0] cs, input logic [10:0] addr, input logic [7:0] data);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_rd = rd;
    cmd_cs = cs;
    cmd_addr = addr;
    cmd_data = data;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic expect_rsp(input logic nack, input logic [7:0] data, input logic rd);
    @(negedge clk);
    while (rsp_valid !== 1'b1) @(negedge clk);
    check("rsp_nack", rsp_nack, nack);
    check("busy", busy, 1'b0);
    if (rd && !nack)
      check("rsp_data", rsp_data, data);
  endtask : expect_rsp

  task automatic pop_word(input logic [10:0] addr, input logic [7:0] data);
    @(negedge clk);
    check("wr_valid", wr_valid, 1'b1);
    check("wr_addr", wr_addr, addr);
    check("wr_data", wr_data, data);
    wr_ready = 1'b1;
    @(negedge clk);
    wr_ready = 1'b0;
  endtask : pop_word

  task automatic wait_prog;
    repeat (WCYC + 20) @(negedge clk);
    check("prog_busy", prog_busy, 1'b0);
  endtask : wait_prog

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("scl", u_sei_if.scl, 1'b1);
    check("sda", u_sei_if.sda_line, 1'b1);
    check("prog_busy", prog_busy, 1'b0);
    check("wr_valid", wr_valid, 1'b0);
    check("busy", busy, 1'b0);
    check("cmd_ready", cmd_ready, 1'b1);
    $display("test reset done");
    // Each single-bit miss first, then the match; read data lines stay released
    for (int i = 0; i < 4; i++) begin
      send(1'b1, strap ^ ((i < 3) ? (3'h1 << i) : 3'h0), 11'h000, 8'h00);
      expect_rsp(i < 3, 8'hFF, 1'b1);
    end
    $display("test select done");
    protect = 1'b1;
    acks_at = acks;
    send(1'b0, strap, 11'h2C4, 8'h3B);
    expect_rsp(1'b1, 8'h00, 1'b0);
    check("acks", acks - acks_at, 32'h2);
    check("prog_busy", prog_busy, 1'b0);
    check("wr_valid", wr_valid, 1'b0);
    protect = 1'b0;
    $display("test protect done");
    send(1'b0, strap, 11'h5A3, 8'hC6);
    send(1'b0, strap, 11'h0E1, 8'h7D);
    expect_rsp(1'b0, 8'h00, 1'b0);
    check("prog_busy", prog_busy, 1'b1);
    expect_rsp(1'b1, 8'h00, 1'b0);
    wait_prog();
    acks_at = acks;
    send(1'b0, strap, 11'h0E1, 8'h7D);
    expect_rsp(1'b0, 8'h00, 1'b0);
    check("acks", acks - acks_at, 32'h3);
    wait_prog();
    send(1'b0, strap, 11'h7FF, 8'h00);
    expect_rsp(1'b1, 8'h00, 1'b0);
    check("prog_busy", prog_busy, 1'b0);
    pop_word(11'h5A3, 8'hC6);
    pop_word(11'h0E1, 8'h7D);
    @(negedge clk);
    check("wr_valid", wr_valid, 1'b0);
    $display("test write done");
    complete_run();
  end
endmodule : serial_eeprom_i2c_slave_front_end_test
